// ### design/pmm_defs.vh
// Address map, field widths and reset values of the paged memory mapper
`ifndef PMM_DEFS_VH
`define PMM_DEFS_VH

// CPU addresses of the mapper's own byte ports
`define PMM_ADDR_PAGE      16'h0078
`define PMM_ADDR_PTR_HI    16'h0079
`define PMM_ADDR_PTR_MID   16'h007a
`define PMM_ADDR_PTR_LO    16'h007b
`define PMM_ADDR_INCR_WORD 16'h007c
`define PMM_ADDR_INCR_BYTE 16'h007d
`define PMM_ADDR_PLAIN     16'h007e
`define PMM_ADDR_PTR_ADD   16'h007f

// Paging window, offset width and page width
`define PMM_WIN_TOP        2'b10
`define PMM_OFS_W          14
`define PMM_PAGE_W         8
`define PMM_PTR_W          22

// Reset values and add port readback value
`define PMM_PAGE_RST       8'h00
`define PMM_PTR_RST        22'h000000
`define PMM_ADD_READBACK   8'h00

`endif

// ### design/pmm_linear_pointer.v
// Linear address pointer: byte loads, post increment and signed add
`include "pmm_defs.vh"

module pmm_linear_pointer #(
    parameter PTR_W = `PMM_PTR_W
) (
    input  wire             clock,
    input  wire             sys_rst,
    input  wire [2:0]       byte_wr,
    input  wire [7:0]       wdata,
    input  wire             incr,
    input  wire             add_en,
    output reg  [PTR_W-1:0] linear_pointer_reg
);
    reg  [PTR_W-1:0] linear_pointer_next;   // Next pointer value
    wire [PTR_W-1:0] add_ext;               // Sign extended offset

    // Two's complement offset widened to the pointer width
    assign add_ext = {{(PTR_W-8){wdata[7]}}, wdata};

    // Next pointer: one source per cycle, wraps silently
    always @* begin
        linear_pointer_next = linear_pointer_reg;
        if (byte_wr[0]) begin
            // Low byte
            linear_pointer_next[7:0] = wdata;
        end else if (byte_wr[1]) begin
            // Middle byte
            linear_pointer_next[15:8] = wdata;
        end else if (byte_wr[2]) begin
            // Top bits, extra written bits dropped
            linear_pointer_next[PTR_W-1:16] = wdata[PTR_W-17:0];
        end else if (incr) begin
            // Step after a post increment access
            linear_pointer_next = linear_pointer_reg + {{(PTR_W-1){1'b0}}, 1'b1};
        end else if (add_en) begin
            // Signed add, 0xff steps back one, 0x80 steps back 128
            linear_pointer_next = linear_pointer_reg + add_ext;
        end
    end

    // Pointer register
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            linear_pointer_reg <= `PMM_PTR_RST;
        end else begin
            linear_pointer_reg <= linear_pointer_next;
        end
    end
endmodule

// ### design/pmm_mapper.v
// Paged memory mapper: page window, paged call/return sequencer, linear data ports
`include "pmm_defs.vh"

// What this block does
// - Window maps onto one selected 16K block
// - Window address joins page and offset
// - Page register loaded by bus, call, return
// - Page one aliases the directly addressed 0x4000 range
// - Call: stack return, push page, load, jump
// - Call sequence holds off interrupts throughout
// - Call supplies immediate page and window target
// - Return: pull page, pull address, resume
// - Return sequence holds off interrupts throughout
// - Linear ports access memory at pointer
// - Increment ports step pointer after access
// - Word port sits just below byte port
// - Add port adds signed byte to pointer
// - Add port reads zero; 0xff minus one
module pmm_mapper #(
    parameter PTR_W  = `PMM_PTR_W,
    parameter PAGE_W = `PMM_PAGE_W
) (
    input  wire              clock,
    input  wire              sys_rst,
    input  wire [15:0]       cpu_addr,
    input  wire [7:0]        cpu_wdata,
    input  wire              cpu_rd,
    input  wire              cpu_wr,
    output wire [7:0]        cpu_rdata,
    output reg               cpu_rdata_valid_reg,
    output wire [PTR_W-1:0]  mem_addr,
    output wire [7:0]        mem_wdata,
    output wire              mem_rd,
    output wire              mem_wr,
    input  wire [7:0]        mem_rdata,
    input  wire              call_req,
    input  wire [PAGE_W-1:0] call_page,
    input  wire [15:0]       call_target,
    input  wire [15:0]       call_return,
    input  wire              ret_req,
    output wire              stack_push,
    output wire [7:0]        stack_push_data,
    output wire              stack_pull,
    input  wire [7:0]        stack_pull_data,
    output reg               pc_load_reg,
    output reg  [15:0]       pc_value_reg,
    output wire              seq_busy,
    output wire [PAGE_W-1:0] program_page_select
);
    // Sequencer states
    localparam S_IDLE    = 4'd0;
    localparam S_PUSH_LO = 4'd1;
    localparam S_PUSH_HI = 4'd2;
    localparam S_PUSH_PG = 4'd3;
    localparam S_LOAD    = 4'd4;
    localparam S_PULL_PG = 4'd5;
    localparam S_PULL_HI = 4'd6;
    localparam S_PULL_LO = 4'd7;
    localparam S_JUMP    = 4'd8;

    reg  [3:0]        state_reg;        // Sequencer state
    reg  [3:0]        state_next;       // Next sequencer state
    reg  [PAGE_W-1:0] page_reg;         // Program page select
    reg  [PAGE_W-1:0] new_page_reg;     // Page operand of a call
    reg  [15:0]       target_reg;       // Target operand of a call
    reg  [15:0]       return_reg;       // Return address being stacked or pulled
    reg  [7:0]        rdata_reg;        // Registered read data of mapper ports
    reg               rdata_mem_reg;    // Last read went to memory
    reg  [7:0]        reg_rdata;        // Combinational read mux
    wire [PTR_W-1:0]  linear_pointer;   // Linear address pointer
    wire              in_window;        // CPU address inside paging window
    wire              hit_plain;        // Plain data port hit
    wire              hit_incr;         // Word or byte increment port hit
    wire              hit_linear;       // Any linear data port hit
    wire              hit_page;         // Page register hit
    wire              hit_add;          // Add port hit
    wire              hit_ptr;          // Pointer byte hit
    wire              access;           // Bus access this cycle
    wire [PTR_W-1:0]  cpu_ext;          // Extended address of an ordinary access
    wire [2:0]        ptr_byte_wr;      // Pointer byte write strobes

    // Port decode; word port one below byte port keeps 16-bit index moves paired
    assign access     = cpu_rd | cpu_wr;
    assign hit_plain  = (cpu_addr == `PMM_ADDR_PLAIN);
    assign hit_incr   = (cpu_addr == `PMM_ADDR_INCR_WORD) |
                        (cpu_addr == `PMM_ADDR_INCR_BYTE);
    assign hit_linear = hit_plain | hit_incr;
    assign hit_page   = (cpu_addr == `PMM_ADDR_PAGE);
    assign hit_add    = (cpu_addr == `PMM_ADDR_PTR_ADD);
    assign hit_ptr    = (cpu_addr == `PMM_ADDR_PTR_HI) |
                        (cpu_addr == `PMM_ADDR_PTR_MID) |
                        (cpu_addr == `PMM_ADDR_PTR_LO);

    // Window test and extended address of CPU accesses
    assign in_window = (cpu_addr[15:14] == `PMM_WIN_TOP);
    // Window joins page and offset; elsewhere zero extend, so page one aliases 0x4000 range
    assign cpu_ext   = in_window ? {page_reg, cpu_addr[`PMM_OFS_W-1:0]}
                                 : {{(PTR_W-16){1'b0}}, cpu_addr};

    // Memory side: linear ports use the pointer, other accesses pass through; page, pointer and add ports raise no strobe
    assign mem_addr  = hit_linear ? linear_pointer : cpu_ext;
    assign mem_wdata = cpu_wdata;
    assign mem_rd    = cpu_rd & ~hit_page & ~hit_add & ~hit_ptr;
    assign mem_wr    = cpu_wr & ~hit_page & ~hit_add & ~hit_ptr;

    // Pointer byte strobes
    assign ptr_byte_wr[0] = cpu_wr & (cpu_addr == `PMM_ADDR_PTR_LO);
    assign ptr_byte_wr[1] = cpu_wr & (cpu_addr == `PMM_ADDR_PTR_MID);
    assign ptr_byte_wr[2] = cpu_wr & (cpu_addr == `PMM_ADDR_PTR_HI);

    // Linear pointer unit
    pmm_linear_pointer #(
        .PTR_W (PTR_W)
    ) u_ptr (
        .clock              (clock),
        .sys_rst            (sys_rst),
        .byte_wr            (ptr_byte_wr),
        .wdata              (cpu_wdata),
        .incr               (access & hit_incr),
        .add_en             (cpu_wr & hit_add),
        .linear_pointer_reg (linear_pointer)
    );

    // Read mux of the mapper's own ports
    always @* begin
        reg_rdata = 8'h00;
        if (hit_page) begin
            reg_rdata = page_reg;
        end else if (cpu_addr == `PMM_ADDR_PTR_HI) begin
            reg_rdata = {{(24-PTR_W){1'b0}}, linear_pointer[PTR_W-1:16]};
        end else if (cpu_addr == `PMM_ADDR_PTR_MID) begin
            reg_rdata = linear_pointer[15:8];
        end else if (cpu_addr == `PMM_ADDR_PTR_LO) begin
            reg_rdata = linear_pointer[7:0];
        end else if (hit_add) begin
            reg_rdata = `PMM_ADD_READBACK;
        end
    end

    // Read data one cycle after the strobe; memory data pass straight through
    assign cpu_rdata = rdata_mem_reg ? mem_rdata : rdata_reg;

    // Read return registers
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg           <= 8'h00;
            rdata_mem_reg       <= 1'b0;
            cpu_rdata_valid_reg <= 1'b0;
        end else begin
            cpu_rdata_valid_reg <= cpu_rd;
            if (cpu_rd) begin
                rdata_reg     <= reg_rdata;
                rdata_mem_reg <= mem_rd;
            end
        end
    end

    // Stack side of the sequencer
    assign stack_push      = (state_reg == S_PUSH_LO) | (state_reg == S_PUSH_HI) |
                             (state_reg == S_PUSH_PG);
    assign stack_push_data = (state_reg == S_PUSH_LO) ? return_reg[7:0] :
                             (state_reg == S_PUSH_HI) ? return_reg[15:8] : page_reg;
    assign stack_pull      = (state_reg == S_PULL_PG) | (state_reg == S_PULL_HI) |
                             (state_reg == S_PULL_LO);
    // Busy holds off interrupts for the whole sequence
    assign seq_busy        = (state_reg != S_IDLE);
    assign program_page_select = page_reg;

    // Sequencer next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                // Call wins if both arrive together
                if (call_req) begin
                    state_next = S_PUSH_LO;
                end else if (ret_req) begin
                    state_next = S_PULL_PG;
                end
            end
            S_PUSH_LO: begin
                state_next = S_PUSH_HI;
            end
            S_PUSH_HI: begin
                state_next = S_PUSH_PG;
            end
            S_PUSH_PG: begin
                state_next = S_LOAD;
            end
            S_PULL_PG: begin
                state_next = S_PULL_HI;
            end
            S_PULL_HI: begin
                state_next = S_PULL_LO;
            end
            S_PULL_LO: begin
                state_next = S_JUMP;
            end
            default: begin
                // Load and jump both end the sequence
                state_next = S_IDLE;
            end
        endcase
    end

    // Sequencer registers, page register and program counter load
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= S_IDLE;
            page_reg     <= `PMM_PAGE_RST;
            new_page_reg <= `PMM_PAGE_RST;
            target_reg   <= 16'h0000;
            return_reg   <= 16'h0000;
            pc_load_reg  <= 1'b0;
            pc_value_reg <= 16'h0000;
        end else begin
            state_reg   <= state_next;
            pc_load_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (call_req) begin
                        // Capture immediate page and window target
                        new_page_reg <= call_page;
                        target_reg   <= call_target;
                        return_reg   <= call_return;
                    end else if (cpu_wr & hit_page) begin
                        // Ordinary store to the page register
                        page_reg <= cpu_wdata[PAGE_W-1:0];
                    end
                end
                S_LOAD: begin
                    // New page and jump to target on the same edge
                    page_reg     <= new_page_reg;
                    pc_load_reg  <= 1'b1;
                    pc_value_reg <= target_reg;
                end
                S_PULL_HI: begin
                    // Saved page arrived from the first pull
                    page_reg <= stack_pull_data[PAGE_W-1:0];
                end
                S_PULL_LO: begin
                    return_reg[15:8] <= stack_pull_data;
                end
                S_JUMP: begin
                    // Resume at the pulled return address
                    pc_load_reg  <= 1'b1;
                    pc_value_reg <= {return_reg[15:8], stack_pull_data};
                end
                default: begin
                    // Push states and the first pull state change no register here
                    pc_load_reg <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ### verification/pmm_checker.sv
// Concurrent checks on the paged memory mapper ports
module pmm_checker #(
    parameter PTR_W  = 22,
    parameter PAGE_W = 8
) (
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic [15:0]       cpu_addr,
    input wire logic              cpu_rd,
    input wire logic              cpu_wr,
    input wire logic [7:0]        cpu_rdata,
    input wire logic              cpu_rdata_valid_reg,
    input wire logic [PTR_W-1:0]  mem_addr,
    input wire logic              mem_rd,
    input wire logic              call_req,
    input wire logic [15:0]       call_return,
    input wire logic              ret_req,
    input wire logic              stack_push,
    input wire logic [7:0]        stack_push_data,
    input wire logic              stack_pull,
    input wire logic [7:0]        stack_pull_data,
    input wire logic              pc_load_reg,
    input wire logic [15:0]       pc_value_reg,
    input wire logic              seq_busy,
    input wire logic [PAGE_W-1:0] program_page_select
);
    timeunit 1ns;
    timeprecision 100ps;
    wire acc  = cpu_rd || cpu_wr;                  // Any CPU byte access
    wire own  = cpu_addr[15:3] == 13'h000f;        // Mapper's own ports
    wire incr = own && cpu_addr[2:1] == 2'b10;     // Stepping data ports
    wire lin  = incr || cpu_addr == 16'h007e;      // Any linear data port
    wire cgo  = call_req && !seq_busy;             // Call taken
    wire rgo  = ret_req && !call_req && !seq_busy; // Return taken
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // Call stacks return low, return high, old page, then loads the PC
    property p_call;
        logic [15:0] r;
        logic [7:0]  p;
        (cgo, r = call_return, p = program_page_select)
        |=> stack_push && stack_push_data == r[7:0] ##1 stack_push && stack_push_data == r[15:8]
        ##1 stack_push && stack_push_data == p ##2 pc_load_reg;
    endproperty
    // Return takes the page from the first pulled byte, then the PC
    property p_ret;
        logic [7:0] pg;
        logic [7:0] hi;
        rgo |=> stack_pull ##1 (stack_pull, pg = stack_pull_data)
        ##1 (stack_pull && program_page_select == pg, hi = stack_pull_data)
        ##2 pc_load_reg && pc_value_reg == {hi, $past(stack_pull_data)};
    endproperty
    chk_call_walk: assert property (p_call) else $error("call walk");
    chk_seq_lock: assert property ((cgo || rgo) |=> seq_busy [*4] ##1 !seq_busy)
        else $error("sequence not atomic");
    chk_ret_walk: assert property (p_ret) else $error("return walk");
    chk_window_map: assert property (acc && cpu_addr[15:14] == 2'b10
        |-> mem_addr == {program_page_select, cpu_addr[13:0]}) else $error("window map");
    chk_low_direct: assert property (acc && !own && cpu_addr[15:14] != 2'b10
        |-> mem_addr == {6'h00, cpu_addr}) else $error("direct map");
    chk_mem_gate: assert property (mem_rd == (cpu_rd && (lin || !own)))
        else $error("memory strobe");
    chk_ptr_step: assert property (acc && lin ##1 acc && lin
        |-> mem_addr == $past(mem_addr) + PTR_W'($past(incr))) else $error("pointer step");
    chk_add_zero: assert property (cpu_rd && cpu_addr == 16'h007f
        |=> cpu_rdata_valid_reg && cpu_rdata == 8'h00) else $error("add port readback");
    cov_call: cover property (cgo);
    cov_ret: cover property (rgo);
    cov_step: cover property (acc && incr ##1 acc && incr);
endmodule
bind pmm_mapper pmm_checker #(.PTR_W(PTR_W), .PAGE_W(PAGE_W)) pmm_checker_inst (.*);

// ### verification/pmm_far_side.sv
// Far-side model: flash byte source and the core's byte stack
module pmm_far_side (
    input  wire logic        clock,
    input  wire logic [21:0] mem_addr,
    input  wire logic        mem_rd,
    output logic      [7:0]  mem_rdata = 8'h5a,
    input  wire logic        stack_push,
    input  wire logic [7:0]  stack_push_data,
    input  wire logic        stack_pull,
    output logic      [7:0]  stack_pull_data = 8'ha5
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] stk [0:15];   // Stacked bytes
    logic [3:0] sp_reg = 4'h0; // Next free slot
    // Flash answers the cycle after a read; an idle bus keeps changing
    always @(posedge clock) begin
        mem_rdata <= mem_rd ? mem_addr[7:0] ^ mem_addr[15:8] ^ {2'h0, mem_addr[21:16]} : ~mem_rdata;
    end
    // Last in, first out; a pulled byte shows the cycle after the pull
    always @(posedge clock) begin
        stack_pull_data <= ~stack_pull_data;
        if (stack_push) begin
            stk[sp_reg] <= stack_push_data;
            sp_reg      <= sp_reg + 4'h1;
        end
        if (stack_pull) begin
            stack_pull_data <= stk[sp_reg-4'h1];
            sp_reg          <= sp_reg - 4'h1;
        end
    end
endmodule

// ### verification/pmm_mapper_tb.sv
// Self-checking bench for the paged memory mapper
module pmm_mapper_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [1:0]  k;    // Bit 1 write, bit 0 memory access
        logic [15:0] addr; // CPU address
        logic [7:0]  wd;   // Write data
        logic [21:0] exp;  // Memory address, or read byte of a mapper port
    } pmm_row_t;
    logic        clock, sys_rst, cpu_rd, cpu_wr, call_req, ret_req, mem_rd, mem_wr;
    logic        cpu_rdata_valid_reg, stack_push, stack_pull, pc_load_reg, seq_busy;
    logic [7:0]  cpu_wdata, call_page, cpu_rdata, mem_wdata, mem_rdata, program_page_select;
    logic [7:0]  stack_push_data, stack_pull_data;
    logic [15:0] cpu_addr, call_target, call_return, pc_value_reg;
    logic [21:0] mem_addr;
    int          error_cnt = 0;
    int          cmp_count = 0;
    // Page writes happen only while running outside paged memory
    pmm_row_t rows [19] = '{'{2'h2, 16'h0078, 8'h05, 22'h0}, '{2'h0, 16'h0078, 8'h00, 22'h5},
        '{2'h1, 16'h8123, 8'h00, 22'h014123}, '{2'h2, 16'h0078, 8'h01, 22'h0},
        '{2'h1, 16'h4abc, 8'h00, 22'h004abc}, '{2'h1, 16'h8abc, 8'h00, 22'h004abc},
        '{2'h2, 16'h0079, 8'h3f, 22'h0}, '{2'h2, 16'h007a, 8'hff, 22'h0},
        '{2'h2, 16'h007b, 8'hfe, 22'h0}, '{2'h1, 16'h007e, 8'h00, 22'h3ffffe},
        '{2'h1, 16'h007c, 8'h00, 22'h3ffffe}, '{2'h3, 16'h007d, 8'ha5, 22'h3fffff},
        '{2'h2, 16'h007f, 8'hff, 22'h0}, '{2'h1, 16'h007e, 8'h00, 22'h3fffff},
        '{2'h2, 16'h007f, 8'h80, 22'h0}, '{2'h3, 16'h007e, 8'h3c, 22'h3fff7f},
        '{2'h0, 16'h0079, 8'h00, 22'h3f}, '{2'h0, 16'h007b, 8'h00, 22'h7f},
        '{2'h0, 16'h007f, 8'h00, 22'h0}};
    pmm_mapper pmm_mapper_inst (.*);
    pmm_far_side pmm_far_side_inst (.*);
    task automatic chk_addr(input string nm, input logic [21:0] e, input logic [21:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        chk_addr(nm, {14'h0, e}, {14'h0, g});
    endtask
    // One CPU byte access: address at once, read data in the next cycle
    task automatic run_row(input pmm_row_t r);
        logic [7:0] rd;
        rd = r.k[0] ? r.exp[7:0] ^ r.exp[15:8] ^ {2'h0, r.exp[21:16]} : r.exp[7:0];
        {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {r.k[1], !r.k[1], r.addr, r.wd};
        #1;
        if (r.k[0]) chk_addr("mem_addr", r.exp, mem_addr);
        if (r.k == 2'h3) chk_byte("mem_wdata", r.wd, mem_wdata);
        chk_byte("mem strobes", {6'h0, r.k == 2'h1, r.k == 2'h3}, {6'h0, mem_rd, mem_wr});
        @(posedge clock);
        #1;
        chk_byte("rdata valid", {7'h0, !r.k[1]}, {7'h0, cpu_rdata_valid_reg});
        if (!r.k[1]) chk_byte("cpu_rdata", rd, cpu_rdata);
    endtask
    // Waits for the PC load; optionally pokes a call while busy; drops held requests
    task automatic wait_pc(input logic poke, input logic [15:0] pc, input logic [7:0] pg);
        int n;
        n = 1;
        call_req = poke;
        while (pc_load_reg !== 1'b1 && n < 12) begin
            @(posedge clock);
            #1;
            {call_req, ret_req, cpu_wr} = 3'h0;
            n++;
        end
        chk_byte("sequence length", 8'h05, n[7:0]);
        chk_addr("pc_value", {6'h0, pc}, {6'h0, pc_value_reg});
        chk_byte("page", pg, program_page_select);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Watchdog well beyond the forty or so cycles the run needs
    initial begin
        #20000;
        error_cnt++;
        test_done;
    end
    initial begin
        {sys_rst, cpu_rd, cpu_wr, call_req, ret_req} = 5'h10;
        {cpu_addr, cpu_wdata, call_page, call_target, call_return} = 64'h0;
        repeat (4) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        foreach (rows[i]) run_row(rows[i]);
        // Call beside a return and a page store held into the first busy cycle; call wins
        {cpu_rd, cpu_wr, cpu_addr, cpu_wdata} = {2'h1, 16'h0078, 8'h77};
        {call_req, ret_req, call_page, call_target, call_return} = {2'h3, 8'h22, 32'h8100_1234};
        @(posedge clock);
        #1;
        wait_pc(1'b0, 16'h8100, 8'h22);
        ret_req = 1'b1;
        @(posedge clock);
        #1;
        ret_req = 1'b0;
        wait_pc(1'b1, 16'h1234, 8'h01);
        repeat (3) @(posedge clock);
        #1;
        chk_byte("busy after return", 8'h00, {7'h0, seq_busy});
        sys_rst = 1'b1;
        #1;
        chk_byte("page in reset", 8'h00, program_page_select);
        @(posedge clock);
        #1;
        sys_rst = 1'b0;
        run_row('{2'h0, 16'h007a, 8'h00, 22'h0});
        test_done;
    end
endmodule
